// file: rtl/sync_rpm_signal_router.sv
`timescale 1ns/1ps
module sync_rpm_signal_router #(
  parameter logic [7:0] BOARD_REVISION = 8'h01,
  parameter logic [7:0] LOGIC_VERSION = 8'h01,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Software configuration
  input logic activate,
  input logic [router_pkg::SEL_W-1:0] sync_sel [router_pkg::NUM_SYNC],
  input logic [router_pkg::NUM_BP_SYNC-1:0] sync_to_backplane,
  input logic [router_pkg::SEL_W-1:0] speed_sel [router_pkg::NUM_SPEED],
  input logic [router_pkg::NUM_SPEED-1:0] speed_to_backplane,
  input logic [router_pkg::NUM_SLOTS-1:0] irq_slot_enable,
  input logic irq_cpu_enable,
  // On-board logic
  input logic [router_pkg::NUM_SYNC-1:0] local_sync,
  input logic cpu_irq_req,
  // Module slots
  input logic [router_pkg::NUM_SYNC-1:0] slot_sync_drive [router_pkg::NUM_SLOTS],
  input logic [router_pkg::SPEED_W-1:0] slot_speed_drive [router_pkg::NUM_SLOTS],
  input logic [router_pkg::NUM_SLOTS-1:0] slot_irq_req,
  output logic [router_pkg::NUM_SYNC-1:0] sync_line,
  output logic [router_pkg::SPEED_W-1:0] speed_bundle_zero,
  output logic [router_pkg::SPEED_W-1:0] speed_bundle_one,
  // Backplane trigger lines, active low, open drain style
  input logic [router_pkg::TRIG_W-1:0] trig_n_in,
  output logic [router_pkg::TRIG_W-1:0] trig_n_out,
  output logic [router_pkg::TRIG_W-1:0] trig_n_oe,
  // Backplane interrupt, active low
  output logic bp_irq_n_out,
  output logic bp_irq_n_oe,
  output logic [router_pkg::NUM_SLOTS:0] irq_source,
  // Local bus pass-through switch
  output logic lbus_connect,
  // Identification data
  output logic [7:0] board_revision,
  output logic [7:0] logic_version,
  output logic [31:0] serial_number
);
  import router_pkg::*;

  generate
    if (NUM_BP_SYNC != NUM_SPEED || NUM_SRC != NUM_SLOTS + 2) begin : g_bad_map
      $error("router trigger map needs matching bundle and sync counts");
    end
  endgenerate

  logic [NUM_SLOTS*NUM_SYNC-1:0] slot_sync_flat;
  logic [NUM_SLOTS*NUM_SYNC-1:0] slot_sync_lvl;
  logic [NUM_SLOTS*SPEED_W-1:0] slot_speed_flat;
  logic [NUM_SLOTS*SPEED_W-1:0] slot_speed_lvl;
  logic [NUM_SLOTS-1:0] slot_irq_lvl;
  logic [TRIG_W-1:0] bp_level;
  logic [NUM_SYNC-1:0] next_sync;
  logic [SPEED_W-1:0] next_speed [NUM_SPEED];
  logic [SPEED_W-1:0] speed_q [NUM_SPEED];
  logic [NUM_SPEED-1:0] speed_drive;
  logic [NUM_BP_SYNC-1:0] sync_drive;
  logic [TRIG_W-1:0] next_trig_n;
  logic [TRIG_W-1:0] next_trig_oe;
  logic [NUM_SLOTS:0] next_irq_source;
  pass_state_t pass_state;
  pass_state_t next_pass_state;

  // Flatten slot inputs for the synchronisers
  generate
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_flat
      assign slot_sync_flat[s*NUM_SYNC +: NUM_SYNC] = slot_sync_drive[s];
      assign slot_speed_flat[s*SPEED_W +: SPEED_W] = slot_speed_drive[s];
    end
  endgenerate

  // Slot pins arrive from other boards' logic
  pin_sync #(.WIDTH(NUM_SLOTS*NUM_SYNC)) u_sync_pins (
    .clk(clk),
    .reset(reset),
    .pin(slot_sync_flat),
    .level(slot_sync_lvl)
  );

  pin_sync #(.WIDTH(NUM_SLOTS*SPEED_W)) u_speed_pins (
    .clk(clk),
    .reset(reset),
    .pin(slot_speed_flat),
    .level(slot_speed_lvl)
  );

  pin_sync #(.WIDTH(NUM_SLOTS)) u_irq_pins (
    .clk(clk),
    .reset(reset),
    .pin(slot_irq_req),
    .level(slot_irq_lvl)
  );

  // Backplane lines inverted to active high before sampling
  pin_sync #(.WIDTH(TRIG_W)) u_trig_pins (
    .clk(clk),
    .reset(reset),
    .pin(~trig_n_in),
    .level(bp_level)
  );

  // Sync line sources: slots, local logic, backplane for lines zero and one only
  generate
    for (genvar l = 0; l < NUM_SYNC; l++) begin : g_sync
      logic [NUM_SRC-1:0] src;
      logic value;
      logic hit;
      for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_src
        assign src[s] = slot_sync_lvl[s*NUM_SYNC+l];
      end
      assign src[NUM_SLOTS] = local_sync[l];
      if (l < NUM_BP_SYNC) begin : g_bp
        assign src[NUM_SLOTS+1] = bp_level[TRG_BUNDLE_STRIDE*l+TRG_SYNC_OFS];
        assign next_sync[l] = hit & value;
      end else begin : g_nobp
        assign src[NUM_SLOTS+1] = 1'b0;
        assign next_sync[l] = hit & value & (sync_sel[l] != SEL_BACKPLANE);
      end
      source_select #(.WIDTH(1), .NUM_SRC(NUM_SRC), .SEL_W(SEL_W)) u_sel (
        .sel(sync_sel[l]),
        .src(src),
        .value(value),
        .hit(hit)
      );
    end
  endgenerate

  // Speed bundle sources: slots, then backplane bundles zero and one
  generate
    for (genvar b = 0; b < NUM_SPEED; b++) begin : g_speed
      logic [NUM_SRC*SPEED_W-1:0] src;
      logic [SPEED_W-1:0] value;
      logic hit;
      logic from_bp;
      assign src[NUM_SLOTS*SPEED_W-1:0] = slot_speed_lvl;
      for (genvar k = 0; k < NUM_SPEED; k++) begin : g_bpsrc
        assign src[(NUM_SLOTS+k)*SPEED_W +: SPEED_W] =
          bp_level[TRG_BUNDLE_STRIDE*k +: SPEED_W];
      end
      source_select #(.WIDTH(SPEED_W), .NUM_SRC(NUM_SRC), .SEL_W(SEL_W)) u_sel (
        .sel(speed_sel[b]),
        .src(src),
        .value(value),
        .hit(hit)
      );
      assign next_speed[b] = hit ? value : SPEED_RESET;
      assign from_bp = (speed_sel[b] == SEL_BP_ZERO) || (speed_sel[b] == SEL_BP_ONE);
      // Never drive the backplane with a bundle taken from it
      assign speed_drive[b] = speed_to_backplane[b] & hit & ~from_bp;
      assign sync_drive[b] = sync_to_backplane[b] & (sync_sel[b] != SEL_BACKPLANE);
      assign next_trig_n[TRG_BUNDLE_STRIDE*b +: SPEED_W] = ~next_speed[b];
      assign next_trig_oe[TRG_BUNDLE_STRIDE*b +: SPEED_W] = {SPEED_W{speed_drive[b]}};
      assign next_trig_n[TRG_BUNDLE_STRIDE*b+TRG_SYNC_OFS] = ~next_sync[b];
      assign next_trig_oe[TRG_BUNDLE_STRIDE*b+TRG_SYNC_OFS] = sync_drive[b];
    end
  endgenerate

  // Sync lines broadcast to slots and local logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_line <= SYNC_RESET;
    end else begin
      sync_line <= next_sync;
    end
  end

  // Speed bundles broadcast to every slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int b = 0; b < NUM_SPEED; b++) begin
        speed_q[b] <= SPEED_RESET;
      end
    end else begin
      for (int b = 0; b < NUM_SPEED; b++) begin
        speed_q[b] <= next_speed[b];
      end
    end
  end

  assign speed_bundle_zero = speed_q[0];
  assign speed_bundle_one = speed_q[1];

  // Backplane trigger drivers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_n_out <= TRIG_N_RESET;
      trig_n_oe <= TRIG_OE_RESET;
    end else begin
      trig_n_out <= next_trig_n;
      trig_n_oe <= next_trig_oe;
    end
  end

  // Interrupt forwarding from slots or the processor
  assign next_irq_source = {cpu_irq_req & irq_cpu_enable, slot_irq_lvl & irq_slot_enable};
  assign bp_irq_n_out = 1'b0;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_source <= IRQ_RESET;
      bp_irq_n_oe <= 1'b0;
    end else begin
      irq_source <= next_irq_source;
      bp_irq_n_oe <= |next_irq_source;
    end
  end

  // Local bus pass-through state
  always_comb begin
    next_pass_state = pass_state;
    unique case (pass_state)
      ST_ISOLATED: begin
        if (activate) begin
          next_pass_state = ST_CONNECTED;
        end
      end
      ST_CONNECTED: begin
        if (!activate) begin
          next_pass_state = ST_ISOLATED;
        end
      end
    endcase
  end

  // Pass-through state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pass_state <= ST_ISOLATED;
    end else begin
      pass_state <= next_pass_state;
    end
  end

  // Switch closes with the state it is about to enter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lbus_connect <= 1'b0;
    end else begin
      lbus_connect <= (next_pass_state == ST_CONNECTED);
    end
  end

  // Identification data held constant
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      board_revision <= BOARD_REVISION;
      logic_version <= LOGIC_VERSION;
      serial_number <= SERIAL_NUMBER;
    end else begin
      board_revision <= board_revision;
      logic_version <= logic_version;
      serial_number <= serial_number;
    end
  end

  // Checks on routing behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  local_sync_a: assert property (
    (sync_sel[0] == SEL_LOCAL) |=> (sync_line[0] == $past(local_sync[0])))
    else $error("sync line zero does not follow local logic");

  slot_sync_a: assert property (
    (sync_sel[1] == SEL_SLOT_BASE + 4'h2) |=> (sync_line[1] == $past(slot_sync_lvl[13])))
    else $error("sync line one does not follow slot two");

  bp_sync_only_a: assert property (
    (sync_sel[2] == SEL_BACKPLANE) |=> !sync_line[2])
    else $error("sync line two took a backplane source");

  sync_drive_a: assert property (
    trig_n_oe[3] |-> ($past(sync_sel[0]) != SEL_BACKPLANE) && $past(sync_to_backplane[0]))
    else $error("sync zero driven while sourced from backplane");

  speed_route_a: assert property (
    (speed_sel[0] == SEL_BP_ONE) |=> (speed_bundle_zero == $past(bp_level[6:4])))
    else $error("bundle zero does not follow backplane bundle one");

  bundle_drive_a: assert property (
    trig_n_oe[4] |-> trig_n_oe[5] && trig_n_oe[6] && (trig_n_out[6:4] == ~speed_bundle_one))
    else $error("bundle one wires not driven together");

  trig_map_a: assert property (
    trig_n_oe[7] |-> (trig_n_out[7] == !sync_line[1]))
    else $error("trigger line seven does not carry sync one");

  irq_forward_a: assert property (
    (cpu_irq_req && irq_cpu_enable) |=> bp_irq_n_oe && irq_source[NUM_SLOTS])
    else $error("processor request not forwarded");

  lbus_gate_a: assert property (
    !activate |=> !lbus_connect [*2] or (activate ##0 1))
    else $error("local bus connected without activation");

  lbus_follow_a: assert property (
    lbus_connect |-> $past(activate))
    else $error("local bus connected before activation");

  ident_hold_a: assert property (
    (board_revision == BOARD_REVISION) && (logic_version == LOGIC_VERSION) &&
    (serial_number == SERIAL_NUMBER))
    else $error("identification data changed");

endmodule

// file: rtl/router_pkg.sv
package router_pkg;

  // Population of the carrier
  localparam int NUM_SLOTS = 6;
  localparam int NUM_SYNC = 6;
  localparam int NUM_SPEED = 2;
  localparam int NUM_BP_SYNC = 2;

  // Speed bundle wires: clock pulse, trigger pulse, direction level
  localparam int SPEED_W = 3;
  localparam int SPD_CLOCK = 0;
  localparam int SPD_TRIGGER = 1;
  localparam int SPD_DIR = 2;

  // Backplane trigger lines: bundle k at 4k..4k+2, sync k at 4k+3
  localparam int TRIG_W = 8;
  localparam int TRG_BUNDLE_STRIDE = 4;
  localparam int TRG_SYNC_OFS = 3;

  // Source select codes, shared by sync lines and speed bundles
  localparam int SEL_W = 4;
  localparam int NUM_SRC = 8;
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_SLOT_BASE = 4'h1;
  localparam logic [3:0] SEL_LOCAL = 4'h7;
  localparam logic [3:0] SEL_BACKPLANE = 4'h8;
  localparam logic [3:0] SEL_BP_ZERO = 4'h7;
  localparam logic [3:0] SEL_BP_ONE = 4'h8;

  // Reset values
  localparam logic [5:0] SYNC_RESET = 6'h00;
  localparam logic [2:0] SPEED_RESET = 3'h0;
  localparam logic [7:0] TRIG_N_RESET = 8'hff;
  localparam logic [7:0] TRIG_OE_RESET = 8'h00;
  localparam logic [6:0] IRQ_RESET = 7'h00;

  // Local bus pass-through state
  typedef enum logic {
    ST_ISOLATED = 1'b0,
    ST_CONNECTED = 1'b1
  } pass_state_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input logic clk,
  input logic reset,
  // Asynchronous pins and their filtered level
  input logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] stage_c;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs at least one bit");
    end
  endgenerate

  // Three flip-flop chain
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage_a <= '0;
      stage_b <= '0;
      stage_c <= '0;
    end else begin
      stage_a <= pin;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  // Accept a change only when second and third stages agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level <= '0;
    end else begin
      level <= (stage_b & stage_c) | (level & (stage_b ^ stage_c));
    end
  end

endmodule

// file: rtl/source_select.sv
`timescale 1ns/1ps
module source_select #(
  parameter int WIDTH = 1,
  parameter int NUM_SRC = 8,
  parameter int SEL_W = 4
) (
  // Select code: zero is none, code k picks source k-1
  input logic [SEL_W-1:0] sel,
  input logic [NUM_SRC*WIDTH-1:0] src,
  // Chosen source and whether the code named one
  output logic [WIDTH-1:0] value,
  output logic hit
);

  generate
    if (NUM_SRC + 1 > (1 << SEL_W) || WIDTH < 1) begin : g_bad_size
      $error("source_select code too narrow for its sources");
    end
  endgenerate

  // One source at most, never a blend
  always_comb begin
    value = '0;
    hit = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (sel == SEL_W'(i + 1)) begin
        value = src[i*WIDTH +: WIDTH];
        hit = 1'b1;
      end
    end
  end

endmodule

// file: verif/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
  // Slot behaviour commanded by the bench
  input logic [router_pkg::NUM_SYNC-1:0] slot_sync_cmd [router_pkg::NUM_SLOTS],
  input logic [router_pkg::SPEED_W-1:0] slot_speed_cmd [router_pkg::NUM_SLOTS],
  input logic [router_pkg::NUM_SLOTS-1:0] slot_irq_cmd,
  // Trigger lines another board pulls low
  input logic [router_pkg::TRIG_W-1:0] other_low,
  // Carrier drive onto the trigger lines
  input logic [router_pkg::TRIG_W-1:0] trig_n_out,
  input logic [router_pkg::TRIG_W-1:0] trig_n_oe,
  // Pins seen by the carrier
  output logic [router_pkg::NUM_SYNC-1:0] slot_sync_drive [router_pkg::NUM_SLOTS],
  output logic [router_pkg::SPEED_W-1:0] slot_speed_drive [router_pkg::NUM_SLOTS],
  output logic [router_pkg::NUM_SLOTS-1:0] slot_irq_req,
  output logic [router_pkg::TRIG_W-1:0] trig_n_in
);
  import router_pkg::*;

  // Modules drive their sync values and clock, trigger, direction bundles
  assign slot_sync_drive = slot_sync_cmd;
  assign slot_speed_drive = slot_speed_cmd;
  assign slot_irq_req = slot_irq_cmd;

  // Wired trigger lines with pull-up; any party pulling low wins
  assign trig_n_in = ~(other_low | (trig_n_oe & ~trig_n_out));
endmodule

// file: verif/sync_rpm_signal_router_tb.sv
`timescale 1ns/1ps
module sync_rpm_signal_router_tb;
  import router_pkg::*;
  typedef struct packed {
    logic [3:0] code;
    logic [5:0] sync;
    logic [2:0] spd;
  } row_t;
  // Identity values are arbitrary
  localparam logic [7:0] REV = 8'h3c;
  localparam logic [7:0] VER = 8'h5e;
  localparam logic [31:0] SER = 32'h1234_abcd;
  // Select code, expected sync lines, expected bundle value
  row_t rows [11] = '{'{4'h0, 6'h00, 3'h0}, '{4'h1, 6'h01, 3'h1}, '{4'h2, 6'h02, 3'h2},
    '{4'h3, 6'h04, 3'h3}, '{4'h4, 6'h08, 3'h4}, '{4'h5, 6'h10, 3'h5}, '{4'h6, 6'h20, 3'h6},
    '{4'h7, 6'h2d, 3'h2}, '{4'h8, 6'h01, 3'h5}, '{4'h9, 6'h00, 3'h0}, '{4'hf, 6'h00, 3'h0}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic activate = 1'b0;
  logic [SEL_W-1:0] sync_sel [NUM_SYNC];
  logic [NUM_BP_SYNC-1:0] sync_to_backplane = 2'h0;
  logic [SEL_W-1:0] speed_sel [NUM_SPEED];
  logic [NUM_SPEED-1:0] speed_to_backplane = 2'h0;
  logic [NUM_SLOTS-1:0] irq_slot_enable = 6'h00;
  logic irq_cpu_enable = 1'b0;
  logic [NUM_SYNC-1:0] local_sync = 6'h2d;
  logic cpu_irq_req = 1'b0;
  logic [NUM_SYNC-1:0] slot_sync_cmd [NUM_SLOTS] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  logic [SPEED_W-1:0] slot_speed_cmd [NUM_SLOTS] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  logic [NUM_SLOTS-1:0] slot_irq_cmd = 6'h00;
  logic [TRIG_W-1:0] other_low = 8'h5a;
  logic [NUM_SYNC-1:0] slot_sync_drive [NUM_SLOTS];
  logic [SPEED_W-1:0] slot_speed_drive [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] slot_irq_req;
  logic [NUM_SYNC-1:0] sync_line;
  logic [SPEED_W-1:0] speed_bundle_zero;
  logic [SPEED_W-1:0] speed_bundle_one;
  logic [TRIG_W-1:0] trig_n_in;
  logic [TRIG_W-1:0] trig_n_out;
  logic [TRIG_W-1:0] trig_n_oe;
  logic bp_irq_n_out;
  logic bp_irq_n_oe;
  logic [NUM_SLOTS:0] irq_source;
  logic lbus_connect;
  logic [7:0] board_revision;
  logic [7:0] logic_version;
  logic [31:0] serial_number;
  int err_total = 0;
  int check_count = 0;

  // Clock
  always #5 clk = ~clk;

  // Modules and other boards
  far_side_model far_side_model_i (.slot_sync_cmd(slot_sync_cmd), .slot_speed_cmd(slot_speed_cmd),
    .slot_irq_cmd(slot_irq_cmd), .other_low(other_low), .trig_n_out(trig_n_out),
    .trig_n_oe(trig_n_oe), .slot_sync_drive(slot_sync_drive),
    .slot_speed_drive(slot_speed_drive), .slot_irq_req(slot_irq_req), .trig_n_in(trig_n_in));

  // Router under test
  sync_rpm_signal_router #(.BOARD_REVISION(REV), .LOGIC_VERSION(VER), .SERIAL_NUMBER(SER))
    sync_rpm_signal_router_i (.clk(clk), .reset(reset), .activate(activate),
    .sync_sel(sync_sel), .sync_to_backplane(sync_to_backplane), .speed_sel(speed_sel),
    .speed_to_backplane(speed_to_backplane), .irq_slot_enable(irq_slot_enable),
    .irq_cpu_enable(irq_cpu_enable), .local_sync(local_sync), .cpu_irq_req(cpu_irq_req),
    .slot_sync_drive(slot_sync_drive), .slot_speed_drive(slot_speed_drive),
    .slot_irq_req(slot_irq_req), .sync_line(sync_line), .speed_bundle_zero(speed_bundle_zero),
    .speed_bundle_one(speed_bundle_one), .trig_n_in(trig_n_in), .trig_n_out(trig_n_out),
    .trig_n_oe(trig_n_oe), .bp_irq_n_out(bp_irq_n_out), .bp_irq_n_oe(bp_irq_n_oe),
    .irq_source(irq_source), .lbus_connect(lbus_connect), .board_revision(board_revision),
    .logic_version(logic_version), .serial_number(serial_number));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Same code on every sync line and both bundles
  task automatic set_all(input logic [3:0] code);
    for (int i = 0; i < NUM_SYNC; i++) begin
      sync_sel[i] = code;
    end
    speed_sel[0] = code;
    speed_sel[1] = code;
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected hundred or so cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    $display("Watchdog expired");
    end_sim();
  end

  // Main sequence
  initial begin
    set_all(4'h0);
    repeat (2) @(negedge clk);
    check("trig_n_oe reset", trig_n_oe, 8'h00);
    check("trig_n_out reset", trig_n_out, 8'hff);
    check("lbus reset", lbus_connect, 1'b0);
    check("irq reset", bp_irq_n_oe, 1'b0);
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    check("lbus idle", lbus_connect, 1'b0);
    check("revision", board_revision, REV);
    check("version", logic_version, VER);
    check("serial", serial_number, SER);
    // Ordinary routing cases
    foreach (rows[r]) begin
      set_all(rows[r].code);
      repeat (6) @(negedge clk);
      check("sync_line", sync_line, rows[r].sync);
      check("speed_bundle_zero", speed_bundle_zero, rows[r].spd);
      check("speed_bundle_one", speed_bundle_one, rows[r].spd);
      check("trig_n_oe quiet", trig_n_oe, 8'h00);
    end
    // Activation closes the pass-through one cycle later
    activate = 1'b1;
    @(negedge clk);
    check("lbus active", lbus_connect, 1'b1);
    // Carrier drives the backplane; bundle one is backplane-sourced so stays off
    other_low = 8'h00;
    local_sync = 6'h01;
    set_all(4'h0);
    sync_sel[0] = SEL_LOCAL;
    sync_sel[1] = SEL_LOCAL;
    speed_sel[0] = 4'h3;
    speed_sel[1] = 4'h8;
    sync_to_backplane = 2'h3;
    speed_to_backplane = 2'h3;
    repeat (2) @(negedge clk);
    check("trig_n_oe drive", trig_n_oe, 8'h8f);
    check("trig_n_out drive", trig_n_out & trig_n_oe, 8'h84);
    sync_sel[0] = SEL_BACKPLANE;
    speed_sel[0] = SEL_NONE;
    @(negedge clk);
    check("trig_n_oe suppress", trig_n_oe, 8'h80);
    // Bundle one taken from slot four is driven onto lines 4 to 6
    speed_sel[1] = 4'h5;
    @(negedge clk);
    check("trig_n_oe bundle one", trig_n_oe, 8'hf0);
    check("trig_n_out bundle one", trig_n_out[6:4], 3'h2);
    // Interrupt forwarding: disabled slot ignored, then slot, then processor
    slot_irq_cmd = 6'h04;
    repeat (6) @(negedge clk);
    check("irq disabled", bp_irq_n_oe, 1'b0);
    irq_slot_enable = 6'h04;
    @(negedge clk);
    check("irq slot", bp_irq_n_oe, 1'b1);
    check("irq slot source", irq_source, 7'h04);
    check("irq level", bp_irq_n_out, 1'b0);
    irq_slot_enable = 6'h00;
    irq_cpu_enable = 1'b1;
    cpu_irq_req = 1'b1;
    @(negedge clk);
    check("irq cpu source", irq_source, 7'h40);
    cpu_irq_req = 1'b0;
    @(negedge clk);
    check("irq cpu off", bp_irq_n_oe, 1'b0);
    // Processor request while its forwarding is disabled
    irq_cpu_enable = 1'b0;
    cpu_irq_req = 1'b1;
    @(negedge clk);
    check("irq cpu refused", bp_irq_n_oe, 1'b0);
    cpu_irq_req = 1'b0;
    // Reset in mid-run opens the pass-through and releases the lines
    reset = 1'b1;
    @(negedge clk);
    check("lbus rereset", lbus_connect, 1'b0);
    check("trig_n_oe rereset", trig_n_oe, 8'h00);
    // Release again with activation still high
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("lbus after rereset", lbus_connect, 1'b1);
    check("trig_n_oe after rereset", trig_n_oe, 8'hf0);
    end_sim();
  end
endmodule
